// File: rtl/bcb_pkg.sv
// bcb_pkg: offsets, field layout, resets and code tables for the
// secondary bus clock and upstream buffer configuration registers.
// assumes a byte-addressed register port with 32-bit words.
package bcb_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_CLK_STRAP = 12'h048;
    localparam logic [11:0] OFF_UPST_BUF = 12'h04c;
    localparam logic [31:0] RST_CLK_STRAP = 32'h00000100;
    localparam logic [31:0] RST_UPST_BUF = 32'h00000307;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int POS_PLL_RATE = 8;
    localparam int POS_LEGACY = 7;
    localparam int POS_CLK_SRC = 3;
    localparam int POS_SPEED_LO = 0;
    localparam int POS_ALLOC_LO = 8;
    localparam int POS_THRES_LO = 0;
    // writable bit masks; everything else reads zero
    localparam logic [31:0] MASK_CLK_STRAP = 32'h0000018f;
    localparam logic [31:0] MASK_UPST_BUF = 32'h0000031f;
    // ----------------------------------------
    // clock selections
    // ----------------------------------------
    typedef enum logic [1:0] {
        BCB_SPD_25 = 2'h0,
        BCB_SPD_33 = 2'h1,
        BCB_SPD_50 = 2'h2,
        BCB_SPD_66 = 2'h3
    } bcb_speed_t;
    localparam int PLL_FAST_MHZ = 400;
    localparam int PLL_SLOW_MHZ = 200;
    // ----------------------------------------
    // buffer sizing
    // ----------------------------------------
    localparam int LEN_W = 11;
    localparam logic [10:0] ALLOC_BASE_BYTES = 11'h080;
    localparam logic [10:0] THRES_STEP_BYTES = 11'h010;
endpackage

// File: rtl/bcb_cfg_field.sv
// bcb_cfg_field: one software-writable field with reset value.
// assumes the parent decodes the write strobe for its register.
`timescale 1ns/1ns
`default_nettype none
module bcb_cfg_field #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] q
);
    logic [W-1:0] q_reg;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_reg <= RST;
        end else if (wr_en) begin
            q_reg <= wr_data;
        end
    end
    assign q = q_reg;
endmodule // bcb_cfg_field
`default_nettype wire

// File: rtl/bcb_config.sv
// bcb_config: secondary bus clock selection and upstream buffer
// configuration, with completion reservation and posted forwarding.
// assumes synchronous inputs and a one-cycle read latency master.
// Functional notes
// R1 - pll rate bit 1 gives a 400 MHz pll and 50/50 duty, 0 gives 200 MHz and 33/66.
// R2 - software should leave the pll rate bit at its reset value of 1.
// R3 - bit 7 written 1 puts the device in legacy mode, reset 0.
// R4 - with clock source 0 the bus clock speed follows the 33/66 MHz strap input.
// R5 - with clock source 1 the bus clock speed follows the speed code, strap ignored.
// R6 - the speed code low two bits pick 25, 33, 50 or 66 MHz, top bit unused, reset 000.
// R7 - the allocation cap code 00..11 means 128, 256, 512, 1024 bytes, reset 11.
// R8 - each upstream read reserves the smaller of the cap and its request size.
// R9 - forwarding of posted data starts once the buffered amount reaches the threshold.
// R10 - threshold code n means 16*(n+1) bytes, reset 00111.
// R11 - other events may also start forwarding before the threshold.
// R12 - reserved bits read zero and writes to them have no effect.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module bcb_config #(
    parameter int ADDR_W = bcb_pkg::ADDR_W,
    parameter int LEN_W = bcb_pkg::LEN_W
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic speed_strap_input,
    output logic pll_rate_select,
    output logic pll_fast,
    output logic legacy_mode,
    output logic [1:0] secondary_bus_clock_speed,
    input wire logic np_rd_valid,
    input wire logic [LEN_W-1:0] np_rd_len,
    output logic [LEN_W-1:0] cpl_reserve_len,
    output logic cpl_reserve_valid,
    input wire logic [LEN_W-1:0] posted_fill_bytes,
    input wire logic posted_flush_event,
    output logic posted_forward_start
);
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire logic hit_clk = (reg_addr == ADDR_W'(bcb_pkg::OFF_CLK_STRAP));
    wire logic hit_buf = (reg_addr == ADDR_W'(bcb_pkg::OFF_UPST_BUF));
    wire logic wr_clk = reg_wr && hit_clk;
    wire logic wr_buf = reg_wr && hit_buf;

    // ----------------------------------------
    // fields
    // ----------------------------------------
    logic pll_rate_q;
    logic legacy_q;
    logic clk_src_q;
    logic [2:0] speed_code_q;
    logic [1:0] completion_alloc_cap;
    logic [4:0] posted_write_threshold;

    // R1 pll rate field
    bcb_cfg_field #(.W(1), .RST(bcb_pkg::RST_CLK_STRAP[bcb_pkg::POS_PLL_RATE])) u_pll (
        .sys_clk(sys_clk), .srst(srst), .wr_en(wr_clk),
        .wr_data(reg_wdata[bcb_pkg::POS_PLL_RATE]), .q(pll_rate_q));
    // R3 legacy mode bit
    bcb_cfg_field #(.W(1), .RST(bcb_pkg::RST_CLK_STRAP[bcb_pkg::POS_LEGACY])) u_leg (
        .sys_clk(sys_clk), .srst(srst), .wr_en(wr_clk),
        .wr_data(reg_wdata[bcb_pkg::POS_LEGACY]), .q(legacy_q));
    bcb_cfg_field #(.W(1), .RST(bcb_pkg::RST_CLK_STRAP[bcb_pkg::POS_CLK_SRC])) u_src (
        .sys_clk(sys_clk), .srst(srst), .wr_en(wr_clk),
        .wr_data(reg_wdata[bcb_pkg::POS_CLK_SRC]), .q(clk_src_q));
    // R6 speed code stored whole
    bcb_cfg_field #(.W(3), .RST(bcb_pkg::RST_CLK_STRAP[bcb_pkg::POS_SPEED_LO +: 3])) u_spd (
        .sys_clk(sys_clk), .srst(srst), .wr_en(wr_clk),
        .wr_data(reg_wdata[bcb_pkg::POS_SPEED_LO +: 3]), .q(speed_code_q));
    // R7 allocation cap field
    bcb_cfg_field #(.W(2), .RST(bcb_pkg::RST_UPST_BUF[bcb_pkg::POS_ALLOC_LO +: 2])) u_cap (
        .sys_clk(sys_clk), .srst(srst), .wr_en(wr_buf),
        .wr_data(reg_wdata[bcb_pkg::POS_ALLOC_LO +: 2]), .q(completion_alloc_cap));
    // R10 threshold field
    bcb_cfg_field #(.W(5), .RST(bcb_pkg::RST_UPST_BUF[bcb_pkg::POS_THRES_LO +: 5])) u_thr (
        .sys_clk(sys_clk), .srst(srst), .wr_en(wr_buf),
        .wr_data(reg_wdata[bcb_pkg::POS_THRES_LO +: 5]), .q(posted_write_threshold));

    // ----------------------------------------
    // clock selection
    // ----------------------------------------
    // R1 pll rate drive
    assign pll_rate_select = pll_rate_q;
    assign pll_fast = pll_rate_q;
    assign legacy_mode = legacy_q;
    // R4 strap picks 33 or 66
    wire logic [1:0] strap_speed = speed_strap_input ? bcb_pkg::BCB_SPD_66 : bcb_pkg::BCB_SPD_33;
    // R5 speed code overrides strap
    wire logic [1:0] speed_next = clk_src_q ? speed_code_q[1:0] : strap_speed;
    logic [1:0] speed_reg;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            speed_reg <= bcb_pkg::BCB_SPD_33;
        end else begin
            speed_reg <= speed_next;
        end
    end
    assign secondary_bus_clock_speed = speed_reg;

    // ----------------------------------------
    // completion reservation
    // ----------------------------------------
    // R7 cap in bytes, 128 shifted by code
    wire logic [LEN_W-1:0] cap_bytes = LEN_W'(bcb_pkg::ALLOC_BASE_BYTES) << completion_alloc_cap;
    // R8 smaller of cap and request
    wire logic [LEN_W-1:0] reserve_next = (np_rd_len < cap_bytes) ? np_rd_len : cap_bytes;
    logic [LEN_W-1:0] reserve_reg;
    logic reserve_vld_reg;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reserve_reg <= '0;
            reserve_vld_reg <= 1'b0;
        end else begin
            reserve_vld_reg <= np_rd_valid;
            if (np_rd_valid) begin
                reserve_reg <= reserve_next;
            end
        end
    end
    assign cpl_reserve_len = reserve_reg;
    assign cpl_reserve_valid = reserve_vld_reg;

    // ----------------------------------------
    // posted forwarding
    // ----------------------------------------
    // R10 threshold 16*(n+1) bytes
    wire logic [LEN_W-1:0] thres_bytes =
        LEN_W'((32'(posted_write_threshold) + 32'd1) * 32'(bcb_pkg::THRES_STEP_BYTES));
    // R9 fill reached threshold
    wire logic thres_hit = (posted_fill_bytes >= thres_bytes);
    logic fwd_reg;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fwd_reg <= 1'b0;
        end else begin
            // R11 other events also forward
            fwd_reg <= thres_hit || posted_flush_event;
        end
    end
    assign posted_forward_start = fwd_reg;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // R12 reserved bits forced zero
    wire logic [31:0] clk_word = bcb_pkg::MASK_CLK_STRAP & {23'h0, pll_rate_q, legacy_q,
        3'h0, clk_src_q, speed_code_q};
    wire logic [31:0] buf_word = bcb_pkg::MASK_UPST_BUF & {22'h0, completion_alloc_cap,
        3'h0, posted_write_threshold};
    wire logic [31:0] rd_sel = hit_clk ? clk_word : (hit_buf ? buf_word : 32'h0);
    logic [31:0] rdata_reg;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_reg <= 32'h0;
        end else if (reg_rd) begin
            rdata_reg <= rd_sel;
        end else begin
            rdata_reg <= 32'h0;
        end
    end
    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // R1 pll output tracks written bit
    AST_PLL_WRITE: assert property (@(posedge sys_clk) disable iff (srst)
        wr_clk |=> pll_fast == $past(reg_wdata[8]))
        else $error("pll rate not taken from write");
    // R3 legacy follows write
    AST_LEGACY: assert property (@(posedge sys_clk) disable iff (srst)
        wr_clk |=> legacy_mode == $past(reg_wdata[7]))
        else $error("legacy bit not taken from write");
    // R4 strap drives speed
    AST_STRAP: assert property (@(posedge sys_clk) disable iff (srst)
        !clk_src_q |=> secondary_bus_clock_speed == ($past(speed_strap_input) ? 2'h3 : 2'h1))
        else $error("strap speed wrong");
    // R5 code drives speed
    AST_CODE: assert property (@(posedge sys_clk) disable iff (srst)
        clk_src_q |=> secondary_bus_clock_speed == $past(speed_code_q[1:0]))
        else $error("coded speed wrong");
    // R8 reservation is the minimum
    AST_RESERVE: assert property (@(posedge sys_clk) disable iff (srst)
        np_rd_valid |=> cpl_reserve_valid && cpl_reserve_len ==
            (($past(np_rd_len) < $past(cap_bytes)) ? $past(np_rd_len) : $past(cap_bytes)))
        else $error("reservation exceeds cap or request");
    // R9 threshold forwarding
    AST_FORWARD: assert property (@(posedge sys_clk) disable iff (srst)
        (posted_fill_bytes >= LEN_W'(16 * (32'(posted_write_threshold) + 1)))
            |=> posted_forward_start)
        else $error("forwarding missed at threshold");
    // R11 flush forwards
    AST_FLUSH: assert property (@(posedge sys_clk) disable iff (srst)
        posted_flush_event |=> posted_forward_start)
        else $error("flush did not forward");
    // R12 reserved bits zero
    AST_RSVD: assert property (@(posedge sys_clk) disable iff (srst)
        reg_rd ##1 1'b1 |-> (reg_rdata & 32'hfffffc60) == 32'h0)
        else $error("reserved bits read nonzero");
    // R6 readback of speed code
    AST_READBACK: assert property (@(posedge sys_clk) disable iff (srst)
        wr_clk ##1 (reg_rd && hit_clk && !reg_wr) |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
        else $error("speed code readback wrong");
    COV_CODE_MODE: cover property (@(posedge sys_clk) disable iff (srst)
        clk_src_q && speed_code_q[1:0] == 2'h2);
    COV_RESERVE_CAPPED: cover property (@(posedge sys_clk) disable iff (srst)
        np_rd_valid && np_rd_len > cap_bytes);
    COV_THRES: cover property (@(posedge sys_clk) disable iff (srst)
        thres_hit && !posted_flush_event);
    COV_LEGACY: cover property (@(posedge sys_clk) disable iff (srst) legacy_mode);
endmodule // bcb_config
`default_nettype wire

// File: tb/test_bcb_config.sv
// test_bcb_config: self-checking bench for the clock and buffer config registers.
// assumes the rtl/ package and design files are compiled before this one.
`timescale 1ns/1ns
`default_nettype none
module test_bcb_config;
    logic sys_clk, srst, reg_wr, reg_rd, speed_strap_input, np_rd_valid, posted_flush_event;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic pll_rate_select, pll_fast, legacy_mode, cpl_reserve_valid, posted_forward_start;
    logic [1:0] secondary_bus_clock_speed;
    logic [10:0] np_rd_len, cpl_reserve_len, posted_fill_bytes;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    bcb_config u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .speed_strap_input(speed_strap_input), .pll_rate_select(pll_rate_select),
        .pll_fast(pll_fast), .legacy_mode(legacy_mode),
        .secondary_bus_clock_speed(secondary_bus_clock_speed), .np_rd_valid(np_rd_valid),
        .np_rd_len(np_rd_len), .cpl_reserve_len(cpl_reserve_len),
        .cpl_reserve_valid(cpl_reserve_valid), .posted_fill_bytes(posted_fill_bytes),
        .posted_flush_event(posted_flush_event), .posted_forward_start(posted_forward_start));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // outputs settle one cycle after the register or strap changes
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic fwd(input logic [10:0] fill, input logic fl, input logic exp);
        @(posedge sys_clk);
        posted_fill_bytes <= fill;
        posted_flush_event <= fl;
        @(posedge sys_clk);
        #1 chk(32'(posted_forward_start), 32'(exp));
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk(12'h048, 32'h00000100);
        @(posedge sys_clk);
        #1 chk(reg_rdata, 32'h0);
        rd_chk(12'h04c, 32'h00000307);
        chk(32'({pll_rate_select, pll_fast, legacy_mode}), 32'h6);
        chk(32'(secondary_bus_clock_speed), 32'h1);
    endtask
    // second reset in mid-run must bring every field back
    task automatic t_rerst();
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
    endtask
    // write then read with no idle cycle between the strobes
    task automatic t_b2b();
        @(posedge sys_clk);
        reg_addr <= 12'h048;
        reg_wdata <= 32'h0000010d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, 32'h0000010d);
    endtask
    task automatic t_strap();
        @(posedge sys_clk) speed_strap_input <= 1'b1;
        settle();
        chk(32'(secondary_bus_clock_speed), 32'h3);
        @(posedge sys_clk) speed_strap_input <= 1'b0;
        settle();
        chk(32'(secondary_bus_clock_speed), 32'h1);
    endtask
    task automatic t_speed();
        for (int c = 0; c < 8; c++) begin
            wr(12'h048, 32'h00000108 | 32'(c));
            // strap always names a speed other than the code's
            @(posedge sys_clk) speed_strap_input <= ~c[1];
            settle();
            chk(32'(secondary_bus_clock_speed), 32'(c & 3));
            rd_chk(12'h048, 32'h00000108 | 32'(c));
        end
    endtask
    task automatic t_bits();
        wr(12'h048, 32'hffffffff);
        rd_chk(12'h048, 32'h0000018f);
        settle();
        chk(32'({pll_rate_select, legacy_mode}), 32'h3);
        @(posedge sys_clk) speed_strap_input <= 1'b0;
        wr(12'h048, 32'h0);
        settle();
        chk(32'({pll_rate_select, pll_fast, legacy_mode}), 32'h0);
        chk(32'(secondary_bus_clock_speed), 32'h1);
        // unmapped place takes nothing and reads zero
        wr(12'h050, 32'hffffffff);
        rd_chk(12'h050, 32'h0);
        rd_chk(12'h048, 32'h0);
        wr(12'h04c, 32'hffffffff);
        rd_chk(12'h04c, 32'h0000031f);
    endtask
    task automatic t_cap();
        logic [10:0] cap;
        for (int c = 0; c < 4; c++) begin
            cap = 11'h080 << c;
            wr(12'h04c, 32'h00000007 | (32'(c) << 8));
            // back-to-back requests, one above and one below the cap
            @(posedge sys_clk);
            np_rd_valid <= 1'b1;
            np_rd_len <= cap + 11'h001;
            @(posedge sys_clk);
            np_rd_len <= cap - 11'h001;
            #1 chk(32'({cpl_reserve_valid, cpl_reserve_len}), 32'({1'b1, cap}));
            @(posedge sys_clk);
            np_rd_valid <= 1'b0;
            #1 chk(32'({cpl_reserve_valid, cpl_reserve_len}), 32'({1'b1, cap - 11'h001}));
            @(posedge sys_clk);
            #1 chk(32'(cpl_reserve_valid), 32'h0);
        end
    endtask
    task automatic t_thres();
        int tv[3] = '{0, 7, 31};
        logic [10:0] th;
        foreach (tv[i]) begin
            th = 11'(16 * (tv[i] + 1));
            wr(12'h04c, 32'h00000300 | 32'(tv[i]));
            fwd(th - 11'h001, 1'b0, 1'b0);
            fwd(th, 1'b0, 1'b1);
            fwd(11'h000, 1'b1, 1'b1);
            fwd(11'h000, 1'b0, 1'b0);
        end
    endtask
    // ----------------------------------------
    // clock, reset, sequence, timeout
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        speed_strap_input = 1'b0;
        np_rd_valid = 1'b0;
        np_rd_len = 11'h000;
        posted_fill_bytes = 11'h000;
        posted_flush_event = 1'b0;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_strap();
        t_speed();
        t_bits();
        t_b2b();
        t_cap();
        t_thres();
        t_rerst();
        conclude();
    end
endmodule // test_bcb_config
`default_nettype wire
